// *** design/accp_config_port.sv ***
/*
 Configuration logic of the converter: strap pins or the serial
 configuration write port select range, mode, coding and shutdown.
 Assumes all pins are asynchronous to clk; the port clock is sampled.
*/
// Notes on behaviour
// - Serial port pins only active when interface select equals 3.
// - Parallel or pin-config-high: settings come from strap pins.
// - Range and mode changes accepted any time, even mid-conversion.
// - In software configuration, strap pins are ignored.
// - Port works only with select 3 and pin-config low.
// - Port select low, then bits sampled on chosen clock edge.
// - Nine bits, MSB first; bit 8 is a start bit, high.
// - Start bit high with port selected begins the load.
// - Ninth clock edge moves shifted bits into active config.
// - Reserved bits 1:0 are left unchanged by port writes.
// - Writes accepted any time, port clock up to 40 MHz.
// - Port usable in all master and slave serial modes.
// - Reset clears every configuration bit to 0.
// - Bits 7 and 6 select input range.
// - Bit 5 high shuts down; later write of 0 restores.
// - Bits 4 and 3 select conversion mode; both high normal.
// - Bit 2 selects twos complement or straight binary.
`timescale 1ns/100ps
module accp_config_port
   import accp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [1:0] interface_sel,
   input wire logic pin_config_sel,
   input wire logic clk_edge_invert,
   input wire logic cfg_serial_clk,
   input wire logic cfg_serial_in,
   input wire logic cfg_port_select_n,
   input wire logic strap_signed_sel,
   input wire logic wide_range_sel,
   input wire logic strap_lowpwr_sel,
   input wire logic strap_fast_sel,
   input wire logic output_coding_sel,
   input wire logic shutdown_ctl,
   output logic [1:0] range_sel,
   output logic [1:0] conv_mode,
   output logic coding_binary,
   output logic power_down,
   output logic [8:0] cfg_active
);
   accp_regs_t r;
   accp_regs_t next_r;
   logic clk_level;
   logic sel_n_level;
   logic port_on;
   logic active_edge;
   logic [8:0] eff;

   assign range_sel = r.range;
   assign conv_mode = r.conv;
   assign coding_binary = r.coding;
   assign power_down = r.shutdown;
   assign cfg_active = r.cfg;

   // -------------------------------------------------------------
   // Decode and sequencing
   // -------------------------------------------------------------
   always_comb begin
      next_r = r;
      // Stage 0 only feeds stage 1; a change counts once 1 and 2 agree
      next_r.clk_sync = {r.clk_sync[1:0], cfg_serial_clk};
      next_r.sel_sync = {r.sel_sync[1:0], cfg_port_select_n};
      next_r.din_sync = {r.din_sync[1:0], cfg_serial_in};
      clk_level = r.clk_prev;
      if (r.clk_sync[2] == r.clk_sync[1]) begin
         clk_level = r.clk_sync[2];
      end
      sel_n_level = r.sel_sync[2] & r.sel_sync[1];
      next_r.clk_prev = clk_level;
      // port gated by mode and pin-config
      // port independent of data read mode
      port_on = (interface_sel == `ACCP_SERIAL_MODE) && !pin_config_sel;
      active_edge = clk_edge_invert ? (r.clk_prev && !clk_level)
                                    : (!r.clk_prev && clk_level);
      unique case (r.state)
         ACCP_IDLE: begin
            next_r.edge_cnt = 4'h0;
            // no busy gating, writes taken any time
            // Selected only once both late stages agree on low
            if (port_on && !r.sel_sync[2] && !r.sel_sync[1] &&
                active_edge && r.din_sync[2]) begin
               next_r.state = ACCP_SHIFT;
               next_r.edge_cnt = 4'h1;
               next_r.shift_reg = 9'h001;
            end
         end
         ACCP_SHIFT: begin
            if (!port_on || sel_n_level) begin
               next_r.state = ACCP_IDLE;
            end else if (active_edge) begin
               next_r.shift_reg = {r.shift_reg[7:0], r.din_sync[2]};
               next_r.edge_cnt = r.edge_cnt + 4'h1;
               if (r.edge_cnt + 4'h1 == `ACCP_EDGE_COUNT) begin
                  next_r.state = ACCP_IDLE;
                  // reserved bits kept
                  // Start bit sits at 7, bits 7..2 of the word below it
                  next_r.cfg = {r.shift_reg[7:1], r.cfg[1:0]};
               end
            end
         end
      endcase
      if (port_on) begin
         eff = next_r.cfg;
      end else begin
         eff = 9'h000;
         eff[`ACCP_BIT_SIGNED] = strap_signed_sel;
         eff[`ACCP_BIT_WIDE] = wide_range_sel;
         eff[`ACCP_BIT_SHUTDOWN] = shutdown_ctl;
         eff[`ACCP_BIT_LOWPWR] = strap_lowpwr_sel;
         eff[`ACCP_BIT_FAST] = strap_fast_sel;
         eff[`ACCP_BIT_CODING] = output_coding_sel;
      end
      next_r.range = accp_range_t'({eff[`ACCP_BIT_SIGNED],
                                    eff[`ACCP_BIT_WIDE]});
      // mode decode, both high is normal
      unique case ({eff[`ACCP_BIT_FAST], eff[`ACCP_BIT_LOWPWR]})
         2'h1: next_r.conv = ACCP_CONV_LOWPWR;
         2'h2: next_r.conv = ACCP_CONV_FAST;
         default: next_r.conv = ACCP_CONV_NORMAL;
      endcase
      next_r.shutdown = eff[`ACCP_BIT_SHUTDOWN];
      next_r.coding = eff[`ACCP_BIT_CODING];
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   // reset clears configuration
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : accp_config_port

// *** design/accp_map.svh ***
/*
 Offsets, field positions, reset values and timing counts of the
 converter configuration block. Assumes inclusion by bare name.
*/
`ifndef ACCP_MAP_SVH
`define ACCP_MAP_SVH
// ----------------------------------------------------------------
// Register layout
// ----------------------------------------------------------------
`define ACCP_CFG_WIDTH 9
`define ACCP_CFG_RESET 9'h000
`define ACCP_BIT_START 8
`define ACCP_BIT_SIGNED 7
`define ACCP_BIT_WIDE 6
`define ACCP_BIT_SHUTDOWN 5
`define ACCP_BIT_LOWPWR 4
`define ACCP_BIT_FAST 3
`define ACCP_BIT_CODING 2
`define ACCP_SERIAL_MODE 2'h3
`define ACCP_EDGE_COUNT 4'h9
`define ACCP_SYNC_STAGES 3
`endif

// *** design/accp_pkg.sv ***
/*
 Types of the converter configuration block.
 Assumes accp_map.svh provides the numeric constants.
*/
`include "accp_map.svh"
package accp_pkg;
   typedef enum logic [1:0] {ACCP_RANGE_0_5, ACCP_RANGE_0_10,
      ACCP_RANGE_PM5, ACCP_RANGE_PM10} accp_range_t;
   typedef enum logic [1:0] {ACCP_CONV_NORMAL, ACCP_CONV_LOWPWR,
      ACCP_CONV_FAST} accp_conv_t;
   typedef enum logic {ACCP_IDLE, ACCP_SHIFT} accp_state_t;
   typedef struct packed {
      logic [2:0] clk_sync;
      logic [2:0] sel_sync;
      logic [2:0] din_sync;
      logic clk_prev;
      accp_state_t state;
      logic [3:0] edge_cnt;
      logic [8:0] shift_reg;
      logic [8:0] cfg;
      accp_range_t range;
      accp_conv_t conv;
      logic shutdown;
      logic coding;
   } accp_regs_t;
endpackage : accp_pkg

// *** testbench/accp_asserts.sv ***
/* Checker of the configuration outputs.
   Assumes it is bound to accp_config_port. */
`timescale 1ns/100ps
module accp_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [1:0] interface_sel,
   input wire logic pin_config_sel,
   input wire logic strap_signed_sel,
   input wire logic wide_range_sel,
   input wire logic output_coding_sel,
   input wire logic shutdown_ctl,
   input wire logic [1:0] range_sel,
   input wire logic [1:0] conv_mode,
   input wire logic coding_binary,
   input wire logic power_down,
   input wire logic [8:0] cfg_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire sw = interface_sel == 2'h3 && !pin_config_sel;
   wire [1:0] sr = {strap_signed_sel, wide_range_sel};
   wire [1:0] ca = cfg_active[4:3];
   logic hw_q;
   logic sw_q;
   // Registered mode history, cleared so the strap and soft checks skip the first edge after reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hw_q <= 1'b0;
         sw_q <= 1'b0;
      end else begin
         hw_q <= !sw;
         sw_q <= sw;
      end
   end
   chk_strap_range: assert property (
      hw_q && !sw |-> range_sel == $past(sr)) else $error("strap range");
   chk_strap_coding: assert property (
      hw_q && !sw |-> coding_binary == $past(output_coding_sel))
      else $error("strap coding");
   chk_strap_power: assert property (
      hw_q && !sw |-> power_down == $past(shutdown_ctl))
      else $error("strap power");
   chk_reserved_zero: assert property (
      cfg_active[1:0] == 2'h0) else $error("reserved bits set");
   chk_start_set: assert property (
      cfg_active != 9'h000 |-> cfg_active[8]) else $error("no start bit");
   chk_cfg_frozen: assert property (
      !sw_q |-> $stable(cfg_active)) else $error("port written off mode");
   chk_sw_range: assert property (
      sw && sw_q && $stable(cfg_active) |-> range_sel == cfg_active[7:6])
      else $error("soft range");
   chk_sw_mode: assert property (
      sw && sw_q && $stable(cfg_active) |->
      conv_mode == {ca == 2'h1, ca == 2'h2})
      else $error("soft mode");
endmodule : accp_asserts

// *** testbench/accp_host_model.sv ***
/* Host that writes the serial configuration port.
   Assumes the caller picks the active clock edge. */
`timescale 1ns/100ps
module accp_host_model (
   output logic sclk,
   output logic sdin,
   output logic sel_n
);
   initial begin
      sclk = 1'b0;
      sdin = 1'b0;
      sel_n = 1'b1;
   end
   // select first, MSB first, 8 MHz link clock
   // clock parked between frames, slow rate
   task automatic send(input logic [8:0] w, input int n, input logic inv);
      sclk = inv;
      #62.5 sel_n = 1'b0;
      for (int i = 8; i > 8 - n; i--) begin
         sdin = w[i];
         #62.5 sclk = ~inv;
         #62.5 sclk = inv;
      end
      #62.5 sel_n = 1'b1;
      sdin = ~sdin;
   endtask : send
endmodule : accp_host_model

// *** testbench/tb.sv ***
/* Bench: straps, serial writes, aborts, refused writes, reset.
   Assumes accp_host_model drives the port pins. */
`timescale 1ns/100ps
module tb;
   logic clk = 0, sys_rst = 1, pcs = 0, inv = 0, sck, sdi, csn, cb, pd;
   logic [1:0] isel = 0, rs, cm;
   logic [5:0] st = 0;
   logic [8:0] cfg, ec, w;
   logic [8:0] tab [4] = '{9'h1FF, 9'h110, 9'h1A4, 9'h108};
   int bad_count = 0, compares = 0;
   always #4 clk = ~clk;
   accp_host_model accp_host_model_i(.sclk(sck), .sdin(sdi), .sel_n(csn));
   accp_config_port accp_config_port_i(.clk(clk), .sys_rst(sys_rst),
      .interface_sel(isel), .pin_config_sel(pcs), .clk_edge_invert(inv),
      .cfg_serial_clk(sck), .cfg_serial_in(sdi), .cfg_port_select_n(csn),
      .strap_signed_sel(st[5]), .wide_range_sel(st[4]),
      .strap_lowpwr_sel(st[3]), .strap_fast_sel(st[2]),
      .output_coding_sel(st[1]), .shutdown_ctl(st[0]), .range_sel(rs),
      .conv_mode(cm), .coding_binary(cb), .power_down(pd), .cfg_active(cfg));
   function automatic logic [5:0] dec(input logic [8:0] c);
      return {c[7:6], c[3] & ~c[4], c[4] & ~c[3], c[2], c[5]};
   endfunction : dec
   task automatic chk(input string n, input logic [8:0] s, e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic finish_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic wr(input logic [8:0] v, input int n);
      accp_host_model_i.send(v, n, inv);
      // settle time after the ninth edge
      repeat (12) @(posedge clk);
      #1;
   endtask : wr
   initial begin
      #100000 bad_count++;
      finish_test;
   end
   initial begin
      void'($urandom(24));
      repeat (5) @(posedge clk);
      #1 sys_rst = 0;
      chk("reset", cfg, 9'h000);
      for (int i = 0; i < 8; i++) begin
         st = 6'($urandom);
         isel = 2'($urandom);
         pcs = isel == 2'h3 || i[0];
         repeat (3) @(posedge clk);
         #1 chk("straps", {3'h0, rs, cm, cb, pd},
            {3'h0, dec({1'b0, st[5:4], st[0], st[3:2], st[1], 2'h0})});
      end
      isel = 2'h3;
      pcs = 0;
      for (int i = 0; i < 12; i++) begin
         inv = i[0];
         st = 6'($urandom);
         w = i < 4 ? tab[i] : {1'b1, 8'($urandom)};
         wr(w, 9);
         ec = {w[8:2], 2'h0};
         chk("cfg", cfg, ec);
         chk("decode", {3'h0, rs, cm, cb, pd}, {3'h0, dec(ec)});
      end
      wr({1'b1, ~ec[7:0]}, 5);
      chk("abort", cfg, ec);
      wr({1'b0, ~ec[7:0]}, 9);
      chk("nostart", cfg, ec);
      pcs = 1;
      wr({1'b1, ~ec[7:0]}, 9);
      chk("hwmode", cfg, ec);
      sys_rst = 1;
      @(posedge clk) #1 sys_rst = 0;
      chk("rereset", cfg, 9'h000);
      finish_test;
   end
endmodule : tb
bind accp_config_port accp_asserts accp_asserts_i(.clk(clk),
   .sys_rst(sys_rst), .interface_sel(interface_sel),
   .pin_config_sel(pin_config_sel), .strap_signed_sel(strap_signed_sel),
   .wide_range_sel(wide_range_sel), .output_coding_sel(output_coding_sel),
   .shutdown_ctl(shutdown_ctl), .range_sel(range_sel),
   .conv_mode(conv_mode), .coding_binary(coding_binary),
   .power_down(power_down), .cfg_active(cfg_active));
